// ===== serial_bus_condition_control.sv
`timescale 1ns/100ps
`default_nettype none
module serial_bus_condition_control
    import sbcc_pkg::*;
(
    input wire logic clk, // System clock, 20 MHz
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [DATA_W-1:0] pwdata, // APB write data
    output logic [DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic xfer_start, // Transfer start instruction, pulse
    input wire logic addr_mismatch, // Received address missed, pulse
    input wire logic ack_detect, // Acknowledge seen after transfer, pulse
    input wire logic scl_in, // Clock line level
    input wire logic sda_in, // Data line level
    output logic sda_out, // Data line drive value
    output logic sda_oe, // Data line pull-down enable
    output logic channel_enable, // Channel enable level
    output logic irq // Interrupt, level
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [1:0] pins_s;
    logic [REG_W-1:0] ctrl_reg;
    logic [REG_W-1:0] ctrl_next;
    logic [REG_W-1:0] mode_reg;
    logic [REG_W-1:0] mode_next;
    logic sol_reg;
    logic sol_next;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] stat_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic irq_reg;
    logic irq_next;
    logic access;
    logic commit;
    logic hit_mode;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_stat;
    logic en;
    logic [REG_W-1:0] ctrl_wval;

    bus_event_if ev ();

    // ****************************************
    // Pin synchronisers and condition detector
    // ****************************************
    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in({scl_in, sda_in}),
        .pin_sync_out(pins_s)
    );

    bus_cond_detect u_det (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .scl_s(pins_s[1]),
        .sda_s(pins_s[0]),
        .ev(ev.src)
    );

    // ****************************************
    // APB decode
    // ****************************************
    // One wait state: the data is registered at the same edge that pready rises
    assign access = ce & psel & penable & ~pready_reg;
    assign commit = ce & psel & penable & pready_reg;
    assign hit_mode = (paddr == ADDR_MODE);
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_stat = (paddr == ADDR_IRQ_STAT);
    assign hit_mask = (paddr == ADDR_IRQ_MASK);
    assign mapped = hit_mode | hit_ctrl | hit_stat | hit_mask;
    assign wr_mode = commit & pwrite & hit_mode;
    assign wr_ctrl = commit & pwrite & hit_ctrl;
    assign wr_mask = commit & pwrite & hit_mask;
    assign rd_stat = commit & ~pwrite & hit_stat;
    assign en = mode_reg[MB_CH_EN];

    always_comb begin
        pready_next = pready_reg;
        pslverr_next = pslverr_reg;
        prdata_next = prdata_reg;
        if (ce) begin
            pready_next = psel & penable & ~pready_reg;
            pslverr_next = access & ~mapped;
            // Writes and unmapped reads return zero data
            if (access) begin
                prdata_next = '0;
                if (pwrite) begin
                    prdata_next = '0;
                end else if (hit_mode) begin
                    prdata_next[REG_W-1:0] = mode_reg & ~MODE_RO_MASK;
                end else if (hit_ctrl) begin
                    prdata_next[REG_W-1:0] = ctrl_reg;
                end else if (hit_stat) begin
                    prdata_next[IRQ_W-1:0] = stat_reg;
                end else if (hit_mask) begin
                    prdata_next[IRQ_W-1:0] = mask_reg;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ****************************************
    // Mode register
    // ****************************************
    always_comb begin
        mode_next = mode_reg;
        if (wr_mode) begin
            mode_next = pwdata[REG_W-1:0] & ~MODE_RO_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************
    // Control register and output latch
    // ****************************************
    // Read-only bits keep their value across a write
    assign ctrl_wval = (pwdata[REG_W-1:0] & ~CTRL_RO_MASK) | (ctrl_reg & CTRL_RO_MASK);

    always_comb begin
        ctrl_next = ctrl_reg;
        sol_next = sol_reg;
        if (ce) begin
            // Triggers self-clear once the latch shows their effect
            if (ctrl_reg[CB_STOP_TRIG] & sol_reg) begin
                ctrl_next[CB_STOP_TRIG] = 1'b0;
            end
            if (ctrl_reg[CB_START_TRIG] & ~sol_reg) begin
                ctrl_next[CB_START_TRIG] = 1'b0;
            end
            // Start trigger wins when both are set
            if (ctrl_reg[CB_START_TRIG]) begin
                sol_next = 1'b0;
            end else if (ctrl_reg[CB_STOP_TRIG]) begin
                sol_next = 1'b1;
            end
            // Clearing events first, so a same-cycle set wins
            if (xfer_start | addr_mismatch) begin
                ctrl_next[CB_STOP_SEEN] = 1'b0;
            end
            if (xfer_start | ev.stop_det) begin
                ctrl_next[CB_START_SEEN] = 1'b0;
            end
            if (xfer_start) begin
                ctrl_next[CB_ACK_SEEN] = 1'b0;
                ctrl_next[CB_ACK_FORCE] = 1'b0;
            end
            if (ev.scl_fall) begin
                ctrl_next[CB_ACK_FORCE] = 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_next[CB_STOP_TRIG] = ctrl_wval[CB_STOP_TRIG];
                ctrl_next[CB_START_TRIG] = ctrl_wval[CB_START_TRIG];
                ctrl_next[CB_ACK_FORCE] = ctrl_wval[CB_ACK_FORCE];
                ctrl_next[CB_ACK_AUTO] = ctrl_wval[CB_ACK_AUTO];
                ctrl_next[CB_BUSY_EN] = ctrl_wval[CB_BUSY_EN];
            end
            if (ev.stop_det) begin
                ctrl_next[CB_STOP_SEEN] = 1'b1;
            end
            if (ev.start_det) begin
                ctrl_next[CB_START_SEEN] = 1'b1;
            end
            if (ack_detect) begin
                ctrl_next[CB_ACK_SEEN] = 1'b1;
            end
            // A stopped channel forces every status and one-shot bit low
            if (~en) begin
                ctrl_next[CB_STOP_TRIG] = 1'b0;
                ctrl_next[CB_START_TRIG] = 1'b0;
                ctrl_next[CB_STOP_SEEN] = 1'b0;
                ctrl_next[CB_START_SEEN] = 1'b0;
                ctrl_next[CB_ACK_SEEN] = 1'b0;
                ctrl_next[CB_ACK_FORCE] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            sol_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            sol_reg <= sol_next;
        end
    end

    // ****************************************
    // Data line drive
    // ****************************************
    // Open drain: only ever pulls low; the latch at one releases the line unless CB_ACK_FORCE is set
    always_comb begin
        sda_oe_next = sda_oe_reg;
        if (ce) begin
            sda_oe_next = en & (~sol_next | ctrl_next[CB_ACK_FORCE]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_oe_reg <= 1'b0;
        end else begin
            sda_oe_reg <= sda_oe_next;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_comb begin
        stat_next = stat_reg;
        mask_next = mask_reg;
        irq_next = irq_reg;
        if (ce) begin
            if (rd_stat) begin
                stat_next = IRQ_RESET;
            end
            // Set after clear so an event in the read cycle is kept
            if (ev.start_det & en) begin
                stat_next[IB_START] = 1'b1;
            end
            if (ev.stop_det & en) begin
                stat_next[IB_STOP] = 1'b1;
            end
            if (ack_detect & en) begin
                stat_next[IB_ACK] = 1'b1;
            end
            if (wr_mask) begin
                mask_next = pwdata[IRQ_W-1:0];
            end
            irq_next = |(stat_next & mask_next);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_reg <= IRQ_RESET;
            mask_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign channel_enable = mode_reg[MB_CH_EN];
    assign irq = irq_reg;
endmodule // serial_bus_condition_control
`default_nettype wire

// ===== sbcc_pkg.sv
package sbcc_pkg;
    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [15:0] IDX_MODE = 16'hff60;
    localparam logic [15:0] IDX_CTRL = 16'hff61;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hff70;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hff71;
    localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CB_STOP_TRIG = 0;
    localparam int CB_START_TRIG = 1;
    localparam int CB_STOP_SEEN = 2;
    localparam int CB_START_SEEN = 3;
    localparam int CB_ACK_FORCE = 4;
    localparam int CB_ACK_AUTO = 5;
    localparam int CB_ACK_SEEN = 6;
    localparam int CB_BUSY_EN = 7;
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [REG_W-1:0] CTRL_RO_MASK = 8'h4c;

    // ****************************************
    // Mode register fields
    // ****************************************
    localparam int MB_CH_EN = 7;
    localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
    localparam logic [REG_W-1:0] MODE_RO_MASK = 8'h40;

    // ****************************************
    // Interrupt status and mask fields
    // ****************************************
    localparam int IRQ_W = 3;
    localparam int IB_START = 0;
    localparam int IB_STOP = 1;
    localparam int IB_ACK = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
endpackage

// ===== bus_event_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bus_event_if;
    logic start_det;
    logic stop_det;
    logic scl_fall;
    logic scl_lvl;
    logic sda_lvl;

    modport src (
        output start_det,
        output stop_det,
        output scl_fall,
        output scl_lvl,
        output sda_lvl
    );
    modport dst (
        input start_det,
        input stop_det,
        input scl_fall,
        input scl_lvl,
        input sda_lvl
    );
endinterface
`default_nettype wire

// ===== pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
    output logic [WIDTH-1:0] pin_sync_out // Two-flop synchronised levels
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    // ****************************************
    // Two flops per bit; first stage is read only by the second
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic meta_next;
            logic sync_reg;
            logic sync_next;
            always_comb begin
                meta_next = ce ? pin_in[i] : meta_reg;
                sync_next = ce ? meta_reg : sync_reg;
            end
            // Idle bus level is high, so reset to one
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'b1;
                    sync_reg <= 1'b1;
                end else begin
                    meta_reg <= meta_next;
                    sync_reg <= sync_next;
                end
            end
            assign pin_sync_out[i] = sync_reg;
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// ===== bus_cond_detect.sv
`timescale 1ns/100ps
`default_nettype none
module bus_cond_detect (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic scl_s, // Synchronised clock line
    input wire logic sda_s, // Synchronised data line
    bus_event_if.src ev // Detected bus events
);
    logic scl_d_reg;
    logic scl_d_next;
    logic sda_d_reg;
    logic sda_d_next;

    always_comb begin
        scl_d_next = ce ? scl_s : scl_d_reg;
        sda_d_next = ce ? sda_s : sda_d_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // ****************************************
    // Conditions: data edge while clock stays high
    // ****************************************
    // Clock must be high before and after, so a clock edge never masquerades
    assign ev.start_det = ce & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign ev.stop_det = ce & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign ev.scl_fall = ce & scl_d_reg & ~scl_s;
    assign ev.scl_lvl = scl_s;
    assign ev.sda_lvl = sda_s;
endmodule // bus_cond_detect
`default_nettype wire

// ===== sbcc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sbcc_asserts
    import sbcc_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic ce, // Enable
    input wire logic [ADDR_W-1:0] paddr, // Address
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [DATA_W-1:0] pwdata, // Write data
    input wire logic [DATA_W-1:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic xfer_start, // Transfer start
    input wire logic addr_mismatch, // Address miss
    input wire logic ack_detect, // Ack seen
    input wire logic scl_in, // Clock line
    input wire logic sda_in, // Data line
    input wire logic sda_out, // Data drive
    input wire logic sda_oe, // Data pull-down
    input wire logic channel_enable, // Channel on
    input wire logic irq // Interrupt
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wr_done;
    logic ctrl_wr;
    assign wr_done = ce && psel && penable && pready && pwrite;
    assign ctrl_wr = wr_done && paddr == ADDR_CTRL && channel_enable;
    a_apb_wait: assert property (ce && psel && penable && !pready |=> pready)
        else $error("pready late");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready && prdata == '0)
        else $error("bad error response");
    a_off_release: assert property (
        !channel_enable && $past(!channel_enable) |-> !sda_oe)
        else $error("line pulled while off");
    a_stop_release: assert property (ctrl_wr && pwdata[CB_STOP_TRIG]
        && !pwdata[CB_START_TRIG] && !pwdata[CB_ACK_FORCE] |-> ##2 !sda_oe [*2])
        else $error("data line not released");
    a_start_drive: assert property (ctrl_wr && pwdata[CB_START_TRIG] |-> ##2 sda_oe)
        else $error("data line not pulled");
    a_ack_drive: assert property (ctrl_wr && pwdata[CB_ACK_FORCE] |=> ##1 sda_oe)
        else $error("ack not driven");
    a_irq_masked: assert property (
        wr_done && paddr == ADDR_IRQ_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("irq despite mask");
endmodule // sbcc_asserts
`default_nettype wire

// ===== bus_peer.sv
`timescale 1ns/100ps
`default_nettype none
module bus_peer (
    output logic scl_drv, // Clock line drive, 1 released
    output logic sda_drv // Data line drive, 1 released
);
    // ****************************************
    // Bus peer, clock idles high between frames
    // ****************************************
    localparam int HALF = 200;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic send_start();
        #13 sda_drv = 1'b0;
        #HALF scl_drv = 1'b0;
        #HALF sda_drv = 1'b1;
        #HALF scl_drv = 1'b1;
        #HALF;
    endtask
    task automatic send_stop();
        #13 scl_drv = 1'b0;
        #HALF sda_drv = 1'b0;
        #HALF scl_drv = 1'b1;
        #HALF sda_drv = 1'b1;
        #HALF;
    endtask
    task automatic clock_pulse();
        #13 scl_drv = 1'b0;
        #HALF scl_drv = 1'b1;
        #HALF;
    endtask
endmodule // bus_peer
`default_nettype wire

// ===== tb_serial_bus_condition_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_serial_bus_condition_control import sbcc_pkg::*;;
    // ****************************************
    // Bench
    // ****************************************
    typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] w, r; logic e;} row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic xfer_start = 1'b0;
    logic addr_mismatch = 1'b0;
    logic ack_detect = 1'b0;
    logic [DATA_W-1:0] prdata, rd;
    logic pready, pslverr, sda_out, sda_oe, channel_enable, irq, er;
    logic scl_drv, sda_drv, sda_line;
    int mismatches = 0;
    int comparisons = 0;
    row_s rows [4] = '{
        '{ADDR_MODE, 32'h000000c0, 32'h00000080, 1'b0},
        '{ADDR_CTRL, 32'h000000ec, 32'h000000a0, 1'b0},
        '{ADDR_IRQ_MASK, 32'h00000007, 32'h00000007, 1'b0},
        '{18'h00000, 32'h0000005a, 32'h00000000, 1'b1}};
    // Open drain with pull-up
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    serial_bus_condition_control i_serial_bus_condition_control (
        .clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_start(xfer_start), .addr_mismatch(addr_mismatch),
        .ack_detect(ack_detect), .scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .channel_enable(channel_enable), .irq(irq));
    bus_peer i_bus_peer (.scl_drv(scl_drv), .sda_drv(sda_drv));
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chkb(input string nm, input logic ex, input logic got);
        chk(nm, {31'h0, ex}, {31'h0, got});
    endtask
    task automatic apb(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwdata <= d;
        pwrite <= w;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("wait states", 32'd2, n);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(a, d, 1'b1);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        apb(a, '0, 1'b0);
        chk("prdata", ex, rd);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        xfer_start <= (k == 0);
        addr_mismatch <= (k == 1);
        ack_detect <= (k == 2);
        @(posedge clk);
        {xfer_start, addr_mismatch, ack_detect} <= 3'h0;
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #500000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_MODE, 32'h0);
        rdc(ADDR_CTRL, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            chkb("pslverr", rows[i].e, er);
            rdc(rows[i].a, rows[i].r);
        end
        chkb("channel_enable", 1'b1, channel_enable);
        chkb("sda_out", 1'b0, sda_out);
        i_bus_peer.send_start();
        settle(2);
        chkb("irq", 1'b1, irq);
        rdc(ADDR_CTRL, 32'ha8);
        rdc(ADDR_IRQ_STAT, 32'h1);
        rdc(ADDR_IRQ_STAT, 32'h0);
        // Clock enable low must swallow the event
        ce <= 1'b0;
        pulse(2);
        ce <= 1'b1;
        rdc(ADDR_IRQ_STAT, 32'h0);
        settle(2);
        chkb("irq", 1'b0, irq);
        i_bus_peer.send_stop();
        rdc(ADDR_CTRL, 32'ha4);
        i_bus_peer.send_start();
        rdc(ADDR_CTRL, 32'hac);
        pulse(0);
        rdc(ADDR_CTRL, 32'ha0);
        i_bus_peer.send_stop();
        pulse(1);
        rdc(ADDR_CTRL, 32'ha0);
        wr(ADDR_CTRL, 32'ha2);
        settle(4);
        chkb("sda_oe", 1'b1, sda_oe);
        rdc(ADDR_CTRL, 32'ha8);
        wr(ADDR_CTRL, 32'ha1);
        settle(4);
        chkb("sda_oe", 1'b0, sda_oe);
        rdc(ADDR_CTRL, 32'ha4);
        wr(ADDR_CTRL, 32'hb0);
        settle(2);
        chkb("sda_oe", 1'b1, sda_oe);
        rdc(ADDR_CTRL, 32'hbc);
        i_bus_peer.clock_pulse();
        settle(2);
        chkb("sda_oe", 1'b0, sda_oe);
        rdc(ADDR_CTRL, 32'hac);
        wr(ADDR_CTRL, 32'hb0);
        settle(6);
        pulse(0);
        settle(8);
        chkb("sda_oe", 1'b0, sda_oe);
        rdc(ADDR_CTRL, 32'ha4);
        chkb("irq", 1'b1, irq);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle(2);
        chkb("irq", 1'b0, irq);
        pulse(2);
        rdc(ADDR_IRQ_STAT, 32'h7);
        wr(ADDR_CTRL, 32'ha2);
        wr(ADDR_MODE, 32'h0);
        settle(2);
        chkb("sda_oe", 1'b0, sda_oe);
        chkb("channel_enable", 1'b0, channel_enable);
        wr(ADDR_CTRL, 32'h13);
        rdc(ADDR_CTRL, 32'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_IRQ_MASK, 32'h0);
        rdc(ADDR_CTRL, 32'h0);
        wrap_up();
    end
endmodule // tb_serial_bus_condition_control
bind serial_bus_condition_control sbcc_asserts i_sbcc_asserts (
    .clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_start(xfer_start), .addr_mismatch(addr_mismatch), .ack_detect(ack_detect),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .channel_enable(channel_enable), .irq(irq));
`default_nettype wire
